// ==== hdl/serial_chain_device.sv ====
// Serial configuration chain logic of one device: pass-through, own load,
// integrity check and done-release start-up.
// Assumes config_clock is far slower than clk_in and is sampled by clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "serial_chain_consts.svh"

module serial_chain_device (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic spi_master_in,
    input wire logic done_pipeline_option_in,
    input wire logic [31:0] forward_bits_in,
    input wire logic [31:0] own_bits_in,
    input wire logic [31:0] expected_check_in,
    input wire logic config_clock_in,
    output logic config_clock_out,
    output logic config_clock_oe_out,
    input wire logic data_in,
    output logic data_out,
    input wire logic done_in,
    output logic done_out,
    output logic done_oe_out,
    output logic global_output_tristate_out,
    output logic fallback_allowed_out,
    output logic limit_reached_out,
    output logic overrun_out,
    output logic check_error_out,
    output logic startup_complete_out
);

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling and edge finding

    logic [2:0] pins_s;
    logic gen_clk_q, gen_clk_d;
    logic [7:0] div_q, div_d;
    logic clk_prev_q, clk_prev_d;
    logic clk_level, rise, fall;
    logic din_s, done_s;

    chain_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({config_clock_in, data_in, done_in}),
        .sync_out(pins_s)
    );

    // A master uses its own divided clock; it is no second domain
    always_comb begin
        din_s = pins_s[1];
        done_s = pins_s[0];
        clk_level = spi_master_in ? gen_clk_q : pins_s[2];
        rise = clk_level && !clk_prev_q;
        fall = !clk_level && clk_prev_q;
        clk_prev_d = clk_level;
        div_d = div_q + 8'h01;
        gen_clk_d = gen_clk_q;
        if (div_q == 8'(`CHAIN_MASTER_HALF_CYC - 1)) begin
            div_d = 8'h00;
            gen_clk_d = ~gen_clk_q;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gen_clk_q <= 1'h0;
            div_q <= 8'h00;
            clk_prev_q <= 1'h0;
        end else begin
            gen_clk_q <= gen_clk_d;
            div_q <= div_d;
            clk_prev_q <= clk_prev_d;
        end
    end

    assign config_clock_out = gen_clk_q;
    assign config_clock_oe_out = spi_master_in;

    ////////////////////////////////////////////////////////////////////////
    // Pass-through buffer

    logic push_valid, buf_ready, buf_valid;
    logic buf_data;
    logic dout_q, dout_d;

    // Buffer absorbs the half period between sampling and driving out
    chain_buffer2 #(
        .WIDTH(1)
    ) u_buf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(push_valid),
        .in_ready_out(buf_ready),
        .in_data_in(din_s),
        .out_valid_out(buf_valid),
        .out_ready_in(fall),
        .out_data_out(buf_data)
    );

    always_comb begin
        dout_d = dout_q;
        if (fall && buf_valid) begin
            dout_d = buf_data;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dout_q <= `CHAIN_DOUT_RST;
        end else begin
            dout_q <= dout_d;
        end
    end

    assign data_out = dout_q;

    ////////////////////////////////////////////////////////////////////////
    // Load, check and start-up sequence

    serial_chain_pkg::chain_state_t state_q, state_d;
    logic [31:0] fwd_cnt_q, fwd_cnt_d;
    logic [31:0] own_cnt_q, own_cnt_d;
    logic [31:0] check_q, check_d;
    logic [1:0] pipe_q, pipe_d;
    logic limit_q, limit_d;
    logic overrun_q, overrun_d;
    logic fwd_done;

    always_comb begin
        state_d = state_q;
        fwd_cnt_d = fwd_cnt_q;
        own_cnt_d = own_cnt_q;
        check_d = check_q;
        pipe_d = pipe_q;
        limit_d = limit_q;
        overrun_d = overrun_q;
        push_valid = 1'h0;
        fwd_done = (fwd_cnt_q >= forward_bits_in) || limit_q;
        case (state_q)
            serial_chain_pkg::ST_FORWARD: begin
                // Downstream data comes first, own data last
                if (fwd_done) begin
                    state_d = serial_chain_pkg::ST_LOAD;
                end else if (rise) begin
                    push_valid = 1'h1;
                    overrun_d = overrun_q || !buf_ready;
                    fwd_cnt_d = fwd_cnt_q + 32'h00000001;
                    if (fwd_cnt_d == `CHAIN_PASS_LIMIT) begin
                        limit_d = 1'h1;
                    end
                end
            end
            serial_chain_pkg::ST_LOAD: begin
                if (own_cnt_q >= own_bits_in) begin
                    state_d = serial_chain_pkg::ST_CHECK;
                end else if (rise) begin
                    own_cnt_d = own_cnt_q + 32'h00000001;
                    check_d = {check_q[30:0], 1'h0} ^
                        ((check_q[31] ^ din_s) ? `CHAIN_CHECK_POLY : 32'h00000000);
                end
            end
            serial_chain_pkg::ST_CHECK: begin
                if (check_q == expected_check_in) begin
                    state_d = serial_chain_pkg::ST_RELEASE;
                end else begin
                    state_d = serial_chain_pkg::ST_ERROR;
                end
            end
            serial_chain_pkg::ST_RELEASE: begin
                // Held here while upstream devices still load
                pipe_d = done_pipeline_option_in ? `CHAIN_DONE_PIPE_EDGES : 2'h0;
                if (done_s) begin
                    state_d = serial_chain_pkg::ST_WAIT_EDGE;
                end
            end
            serial_chain_pkg::ST_WAIT_EDGE: begin
                if (rise) begin
                    if (pipe_q == 2'h0) begin
                        state_d = serial_chain_pkg::ST_FINISH;
                    end else begin
                        pipe_d = pipe_q - 2'h1;
                    end
                end
            end
            serial_chain_pkg::ST_FINISH: begin
                state_d = serial_chain_pkg::ST_FINISH;
            end
            serial_chain_pkg::ST_ERROR: begin
                // Only a reset restarts; no earlier image to fall back on
                state_d = serial_chain_pkg::ST_ERROR;
            end
            default: begin
                state_d = serial_chain_pkg::ST_ERROR;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= serial_chain_pkg::ST_FORWARD;
            fwd_cnt_q <= 32'h00000000;
            own_cnt_q <= 32'h00000000;
            check_q <= `CHAIN_CHECK_INIT;
            pipe_q <= 2'h0;
            limit_q <= 1'h0;
            overrun_q <= 1'h0;
        end else begin
            state_q <= state_d;
            fwd_cnt_q <= fwd_cnt_d;
            own_cnt_q <= own_cnt_d;
            check_q <= check_d;
            pipe_q <= pipe_d;
            limit_q <= limit_d;
            overrun_q <= overrun_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs

    logic released;

    // Done is driven low until release; the open-drain pull-up raises it
    always_comb begin
        released = (state_q == serial_chain_pkg::ST_RELEASE) ||
            (state_q == serial_chain_pkg::ST_WAIT_EDGE) ||
            (state_q == serial_chain_pkg::ST_FINISH);
    end

    assign done_out = 1'h0;
    assign done_oe_out = !released;
    assign global_output_tristate_out = !released;
    assign fallback_allowed_out = 1'h0;
    assign limit_reached_out = limit_q;
    assign overrun_out = overrun_q;
    assign check_error_out = (state_q == serial_chain_pkg::ST_ERROR);
    assign startup_complete_out = (state_q == serial_chain_pkg::ST_FINISH);

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_fwd_push;
        @(posedge clk_in) disable iff (rst_in)
        (state_q == serial_chain_pkg::ST_FORWARD) && !fwd_done && rise
            |=> (fwd_cnt_q == $past(fwd_cnt_q) + 32'h00000001);
    endproperty
    a_fwd_push: assert property (p_fwd_push) else $error("forward bit not counted");

    property p_dout_fall;
        @(posedge clk_in) disable iff (rst_in)
        $changed(dout_q) |-> $past(fall);
    endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("output moved off falling edge");

    property p_load_rise;
        @(posedge clk_in) disable iff (rst_in)
        $changed(own_cnt_q) |-> $past(rise) && $past(state_q == serial_chain_pkg::ST_LOAD);
    endproperty
    a_load_rise: assert property (p_load_rise) else $error("own bit taken off rising edge");

    property p_order;
        @(posedge clk_in) disable iff (rst_in)
        (state_q == serial_chain_pkg::ST_LOAD) |-> fwd_done;
    endproperty
    a_order: assert property (p_order) else $error("own load before forwarding ended");

    property p_check_own;
        @(posedge clk_in) disable iff (rst_in)
        (state_q == serial_chain_pkg::ST_FORWARD) |=> $stable(check_q);
    endproperty
    a_check_own: assert property (p_check_own) else $error("check touched by forwarded data");

    property p_release_hold;
        @(posedge clk_in) disable iff (rst_in)
        (state_q == serial_chain_pkg::ST_RELEASE) && !done_s
            |=> (state_q == serial_chain_pkg::ST_RELEASE) && !done_oe_out;
    endproperty
    a_release_hold: assert property (p_release_hold) else $error("left release early");

    property p_leave;
        @(posedge clk_in) disable iff (rst_in)
        (state_q == serial_chain_pkg::ST_WAIT_EDGE) && rise && (pipe_q == 2'h0)
            |=> startup_complete_out;
    endproperty
    a_leave: assert property (p_leave) else $error("start-up not completed on edge");

    property p_limit;
        @(posedge clk_in) disable iff (rst_in)
        limit_q |=> (fwd_cnt_q == `CHAIN_PASS_LIMIT) && $stable(fwd_cnt_q);
    endproperty
    a_limit: assert property (p_limit) else $error("pass-through limit exceeded");

    property p_gts;
        @(posedge clk_in) disable iff (rst_in)
        $fell(done_oe_out) |-> !global_output_tristate_out && $past(global_output_tristate_out);
    endproperty
    a_gts: assert property (p_gts) else $error("tristate released after done");

    property p_pipe;
        @(posedge clk_in) disable iff (rst_in)
        (state_q == serial_chain_pkg::ST_RELEASE) && done_s && done_pipeline_option_in
            |=> (pipe_q == `CHAIN_DONE_PIPE_EDGES);
    endproperty
    a_pipe: assert property (p_pipe) else $error("done pipeline delay missing");

endmodule : serial_chain_device

`default_nettype wire

// ==== common/serial_chain_consts.svh ====
// Constants for the serial configuration chain device.
// Assumes inclusion by bare name from design files and from the bench.
`ifndef SERIAL_CHAIN_CONSTS_SVH
`define SERIAL_CHAIN_CONSTS_SVH

// Most bits one device may pass on toward the far end of the chain
`define CHAIN_PASS_LIMIT 32'hFFFFFFE0
// Integrity check polynomial and start value
`define CHAIN_CHECK_POLY 32'h04C11DB7
`define CHAIN_CHECK_INIT 32'hFFFFFFFF
// Master clock half period as a time and as a clk_in cycle count
`define CHAIN_CLK_PERIOD_NS 10
`define CHAIN_MASTER_HALF_NS 40
`define CHAIN_MASTER_HALF_CYC (`CHAIN_MASTER_HALF_NS / `CHAIN_CLK_PERIOD_NS)
// Extra config_clock rising edges added by the done pipeline option
`define CHAIN_DONE_PIPE_EDGES 2'h1
// Reset values
`define CHAIN_DOUT_RST 1'h1

`endif

// ==== common/serial_chain_pkg.sv ====
// Types shared by the serial configuration chain device.
// Assumes the constants header is compiled alongside.
package serial_chain_pkg;

    typedef enum logic [6:0] {
        ST_FORWARD = 7'h01,
        ST_LOAD = 7'h02,
        ST_CHECK = 7'h04,
        ST_RELEASE = 7'h08,
        ST_WAIT_EDGE = 7'h10,
        ST_FINISH = 7'h20,
        ST_ERROR = 7'h40
    } chain_state_t;

endpackage : serial_chain_pkg

// ==== hdl/chain_sync2.sv ====
// Two flip-flop synchroniser for levels coming from pins.
// Assumes inputs are quasi static relative to clk_in.
`timescale 1ns/1ps
`default_nettype none

module chain_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] stable_d;

    // First stage feeds only the second stage
    always_comb begin
        meta_d = async_in;
        stable_d = meta_q;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            stable_q <= '0;
        end else begin
            meta_q <= meta_d;
            stable_q <= stable_d;
        end
    end

    assign sync_out = stable_q;

endmodule : chain_sync2

`default_nettype wire

// ==== hdl/chain_buffer2.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; push and pop may occur in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module chain_buffer2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic wr_q, wr_d, rd_q, rd_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = in_valid_in && (cnt_q != 2'h2);
        pop = out_ready_in && (cnt_q != 2'h0);
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data_in;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        cnt_d = cnt_q + {1'h0, push} - {1'h0, pop};
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q <= 1'h0;
            rd_q <= 1'h0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    assign in_ready_out = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out = mem_q[rd_q];

endmodule : chain_buffer2

`default_nettype wire

// ==== bench/chain_upstream.sv ====
// Upstream source model: makes config_clock and serial data, and the shared done line.
// Assumes the bench calls send_bits; the clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none

module chain_upstream (
    input wire logic hold_low_in,
    input wire logic done_oe_in,
    input wire logic done_drv_in,
    output logic clk_out,
    output logic data_out,
    output logic done_line_out
);
    initial begin
        clk_out = 1'h0;
        data_out = 1'h0;
    end

    // Pull-up wins only when no party holds the line low
    assign done_line_out = !hold_low_in && !(done_oe_in && !done_drv_in);

    ////////////////////////////////////////////////////////////////////////////////
    // One shared clock and data net, so every listener sees the same transitions
    // MSB first, data set half a period before each rise
    task automatic send_bits(input logic [31:0] v, input int n);
        #3;
        for (int i = n - 1; i >= 0; i--) begin
            data_out = v[i];
            #40 clk_out = 1'h1;
            #40 clk_out = 1'h0;
        end
        // Released data shows the inverse so a stale bit never passes
        data_out = !data_out;
    endtask : send_bits
endmodule : chain_upstream

`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for one serial chain device in slave and master mode.
// Assumes the upstream model stands in for the source and the other devices.
`timescale 1ns/1ps
`default_nettype none
`include "serial_chain_consts.svh"

`define CHECK(what, exp, act) begin comparisons++; if ((act) !== (exp)) begin \
    miscompares++; $display("mismatch %s expected %0h seen %0h", what, exp, act); end end

module tb;
    logic clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic spi_master_in = 1'h0;
    logic pipe_in = 1'h0;
    logic hold_q = 1'h1;
    logic cap_en = 1'h0;
    logic [31:0] fwd_in = 32'h0;
    logic [31:0] own_in = 32'h0;
    logic [31:0] exp_in = 32'hFFFFFFFF;
    logic config_clock_o, config_clock_oe, up_clk, up_data, dout, done_o, done_oe, done_line;
    logic global_output_tristate, fallback, limit, overrun, chk_err, started;
    logic cap_q[$];
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    wire cfg_pin = config_clock_oe ? config_clock_o : up_clk;

    always #5 clk_in = !clk_in;

    chain_upstream u_up (.hold_low_in(hold_q), .done_oe_in(done_oe), .done_drv_in(done_o),
        .clk_out(up_clk), .data_out(up_data), .done_line_out(done_line));

    serial_chain_device dut (.clk_in(clk_in), .rst_in(rst_in), .spi_master_in(spi_master_in),
        .done_pipeline_option_in(pipe_in), .forward_bits_in(fwd_in), .own_bits_in(own_in),
        .expected_check_in(exp_in), .config_clock_in(cfg_pin), .config_clock_out(config_clock_o),
        .config_clock_oe_out(config_clock_oe), .data_in(up_data), .data_out(dout),
        .done_in(done_line), .done_out(done_o), .done_oe_out(done_oe),
        .global_output_tristate_out(global_output_tristate), .fallback_allowed_out(fallback),
        .limit_reached_out(limit), .overrun_out(overrun), .check_error_out(chk_err),
        .startup_complete_out(started));

    // Downstream view: bit taken a little after each rising edge
    always @(posedge cfg_pin) begin
        #20;
        if (cap_en) cap_q.push_back(dout);
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] crc_own(input logic [15:0] v);
        logic [31:0] c;
        c = `CHAIN_CHECK_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = {c[30:0], 1'h0} ^ ((c[31] ^ v[i]) ? `CHAIN_CHECK_POLY : 32'h0);
        end
        return c;
    endfunction : crc_own

    task automatic do_reset(input logic sm, input logic pp, input logic [31:0] f,
        input logic [31:0] o, input logic [31:0] e);
        @(posedge clk_in);
        rst_in <= 1'h1;
        spi_master_in <= sm;
        pipe_in <= pp;
        fwd_in <= f;
        own_in <= o;
        exp_in <= e;
        hold_q <= 1'h1;
        repeat (3) @(posedge clk_in);
        `CHECK("dout_rst", `CHAIN_DOUT_RST, dout)
        `CHECK("done_oe_rst", 1'h1, done_oe)
        `CHECK("done_drive", 1'h0, done_o)
        `CHECK("gts_rst", 1'h1, global_output_tristate)
        `CHECK("fallback", 1'h0, fallback)
        `CHECK("limit_rst", 1'h0, limit)
        rst_in <= 1'h0;
        @(posedge clk_in);
    endtask : do_reset

    task automatic wait_release();
        int n;
        n = 0;
        while (done_oe !== 1'h0 && n < 300) begin
            @(posedge clk_in);
            n++;
        end
        #1;
        `CHECK("release", 1'h0, done_oe)
        `CHECK("gts_with_done", 1'h0, global_output_tristate)
    endtask : wait_release

    ////////////////////////////////////////////////////////////////////////////////
    // Eight bits pass through, sixteen own bits load; start-up waits for the shared line
    task automatic test_load(input logic pp);
        logic [7:0] f;
        logic [15:0] o;
        f = 8'h96;
        o = 16'hA5C3;
        do_reset(1'h0, pp, 32'h8, 32'h10, crc_own(o));
        `CHECK("clk_oe_slave", 1'h0, config_clock_oe)
        cap_q.delete();
        cap_en = 1'h1;
        u_up.send_bits({24'h0, f}, 8);
        u_up.send_bits({16'h0, o}, 16);
        cap_en = 1'h0;
        for (int i = 0; i < 8; i++) begin
            `CHECK("fwd_bit", f[7 - i], cap_q[i + 1])
        end
        wait_release();
        `CHECK("check_ok", 1'h0, chk_err)
        u_up.send_bits(32'h55555555, 2);
        `CHECK("held", 1'h0, started)
        @(posedge clk_in);
        hold_q <= 1'h0;
        repeat (4) @(posedge clk_in);
        u_up.send_bits(32'h55555555, 1);
        `CHECK("start_first", !pp, started)
        u_up.send_bits(32'h55555555, 1);
        `CHECK("start_second", 1'h1, started)
        `CHECK("overrun", 1'h0, overrun)
        $display("test_load pipe=%0d done", pp);
    endtask : test_load

    // Bad check value: no release, held in error
    task automatic test_bad_check();
        do_reset(1'h0, 1'h0, 32'h0, 32'h0, 32'h0);
        repeat (30) @(posedge clk_in);
        `CHECK("check_err", 1'h1, chk_err)
        `CHECK("no_release", 1'h1, done_oe)
        `CHECK("no_fallback", 1'h0, fallback)
        $display("test_bad_check done");
    endtask : test_bad_check

    // Master mode drives config_clock at two master half periods
    task automatic test_master();
        int n;
        int per;
        do_reset(1'h1, 1'h0, 32'h8, 32'h8, 32'h0);
        `CHECK("clk_oe", 1'h1, config_clock_oe)
        n = 0;
        // Find a low-to-high step of the generated clock without sampled-value calls
        while (config_clock_o !== 1'h0 && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        while (config_clock_o !== 1'h1 && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        per = 0;
        do begin
            @(posedge clk_in);
            per++;
        end while (config_clock_o !== 1'h0 && per < 100);
        do begin
            @(posedge clk_in);
            per++;
        end while (config_clock_o !== 1'h1 && per < 100);
        `CHECK("clk_period", 2 * `CHAIN_MASTER_HALF_CYC, per)
        $display("test_master done");
    endtask : test_master

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // Whole run needs several hundred cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        test_load(1'h0);
        test_load(1'h1);
        test_bad_check();
        test_master();
        test_done();
    end
endmodule : tb

`default_nettype wire
